//--- hw/parity_status_pkg.sv
package parity_status_pkg;

    // register bus geometry
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;

    // register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] MASK_OFFSET   = 8'h08;

    // control register fields
    localparam int CTRL_PRI_RESP_BIT = 0;
    localparam int CTRL_SEC_RESP_BIT = 1;
    localparam int CTRL_WIDTH        = 2;

    // status and mask register fields
    localparam int STAT_PRI_DET_BIT  = 0;
    localparam int STAT_SEC_DET_BIT  = 1;
    localparam int STAT_PRI_MDPE_BIT = 2;
    localparam int STAT_SEC_MDPE_BIT = 3;
    localparam int STAT_WIDTH        = 4;

    // reset values
    localparam logic [1:0] CTRL_RESET   = 2'h0;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET   = 4'h0;
    localparam logic       PIN_IDLE     = 1'h1;

    // transaction kind of a reported parity event
    typedef enum logic [1:0] {
        TXN_READ    = 2'b00,
        TXN_POSTED  = 2'b01,
        TXN_DELAYED = 2'b10
    } txn_type;

    typedef txn_type txn_kind_type;

    // direction of the transaction through the bridge
    typedef enum logic {
        DIR_DOWN = 1'b0,
        DIR_UP   = 1'b1
    } dir_type;

    // bus on which the bad parity was seen
    typedef enum logic {
        BUS_PRIMARY   = 1'b0,
        BUS_SECONDARY = 1'b1
    } bus_type;

endpackage : parity_status_pkg

//--- hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int         WIDTH     = 2,
    parameter logic [1:0] RESET_VAL = 2'h3
) (
    // clock, reset, enable
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_ce,
    // asynchronous pins in, synchronised levels out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    // first stage feeds only the second stage
    always_comb begin
        next_meta = meta;
        next_sync = o_sync;
        if (i_ce) begin
            next_meta = i_async;
            next_sync = meta;
        end
    end

    // two flip-flop chain, idle level under reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta   <= RESET_VAL[WIDTH-1:0];
            o_sync <= RESET_VAL[WIDTH-1:0];
        end else begin
            meta   <= next_meta;
            o_sync <= next_sync;
        end
    end

endmodule : pin_sync

//--- hw/parity_status.sv
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module parity_status
    import parity_status_pkg::*;
(
    // clock, reset, enable
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_ce,
    // register port
    input  wire logic [ADDR_WIDTH-1:0] i_addr,
    input  wire logic [DATA_WIDTH-1:0] i_wdata,
    input  wire logic                  i_write,
    input  wire logic                  i_read,
    output logic      [DATA_WIDTH-1:0] o_rdata,
    // parity check results from the bridge datapath
    input  wire logic                  i_err_valid,
    input  wire txn_kind_type          i_err_type,
    input  wire dir_type               i_err_dir,
    input  wire bus_type               i_err_bus,
    // bus mastership from the bridge datapath
    input  wire logic                  i_primary_master,
    input  wire logic                  i_secondary_master,
    // parity error pins driven by targets
    input  wire logic                  i_primary_parity_err_n,
    input  wire logic                  i_secondary_parity_err_n,
    // enables and interrupt
    output logic                       o_primary_perr_resp,
    output logic                       o_secondary_perr_resp,
    output logic                       o_irq
);

    logic [CTRL_WIDTH-1:0] ctrl;
    logic [CTRL_WIDTH-1:0] next_ctrl;
    logic [STAT_WIDTH-1:0] status;
    logic [STAT_WIDTH-1:0] next_status;
    logic [STAT_WIDTH-1:0] mask;
    logic [STAT_WIDTH-1:0] next_mask;
    logic [STAT_WIDTH-1:0] set_vec;
    logic [STAT_WIDTH-1:0] clr_vec;
    logic [DATA_WIDTH-1:0] next_rdata;
    logic                  next_irq;
    logic [1:0]            pins_sync;
    logic                  pri_pin_err;
    logic                  sec_pin_err;
    logic                  pri_det_evt;
    logic                  sec_det_evt;
    logic                  pri_mdpe_evt;
    logic                  sec_mdpe_evt;

    // true when the event belongs to the detected flag of one interface
    function automatic logic det_hit(input txn_kind_type t,
                                     input dir_type      d,
                                     input bus_type      b,
                                     input bus_type      side);
        dir_type read_dir;
        read_dir = (side == BUS_PRIMARY) ? DIR_UP : DIR_DOWN;
        if (b != side) begin
            det_hit = 1'b0;
        end else if (t == TXN_READ) begin
            det_hit = (d == read_dir);
        end else if (t == TXN_POSTED || t == TXN_DELAYED) begin
            det_hit = (d != read_dir);
        end else begin
            det_hit = 1'b0;
        end
    endfunction : det_hit

    // target driven parity pins, brought into the clock domain
    pin_sync #(
        .WIDTH     (2),
        .RESET_VAL ({PIN_IDLE, PIN_IDLE})
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_ce    (i_ce),
        .i_async ({i_secondary_parity_err_n, i_primary_parity_err_n}),
        .o_sync  (pins_sync)
    );

    assign pri_pin_err = ~pins_sync[0];
    assign sec_pin_err = ~pins_sync[1];

    // detected flags, independent of both response enables
    assign pri_det_evt = i_err_valid
        && det_hit(i_err_type, i_err_dir, i_err_bus, BUS_PRIMARY);
    assign sec_det_evt = i_err_valid
        && det_hit(i_err_type, i_err_dir, i_err_bus, BUS_SECONDARY);

    // master data parity flags, gated by mastership and enable
    assign pri_mdpe_evt = i_primary_master
        && ctrl[CTRL_PRI_RESP_BIT]
        && (pri_pin_err
            || (i_err_valid && i_err_bus == BUS_PRIMARY
                && i_err_dir == DIR_UP));
    assign sec_mdpe_evt = i_secondary_master
        && ctrl[CTRL_SEC_RESP_BIT]
        && (sec_pin_err
            || (i_err_valid && i_err_bus == BUS_SECONDARY
                && i_err_dir == DIR_DOWN));

    // register writes, sticky flags with set winning over clear
    always_comb begin
        set_vec = STATUS_RESET;
        set_vec[STAT_PRI_DET_BIT]  = pri_det_evt;
        set_vec[STAT_SEC_DET_BIT]  = sec_det_evt;
        set_vec[STAT_PRI_MDPE_BIT] = pri_mdpe_evt;
        set_vec[STAT_SEC_MDPE_BIT] = sec_mdpe_evt;
        clr_vec   = STATUS_RESET;
        next_ctrl = ctrl;
        next_mask = mask;
        if (i_write) begin
            if (i_addr == CTRL_OFFSET) begin
                next_ctrl = i_wdata[CTRL_WIDTH-1:0];
            end else if (i_addr == STATUS_OFFSET) begin
                clr_vec = i_wdata[STAT_WIDTH-1:0];
            end else if (i_addr == MASK_OFFSET) begin
                next_mask = i_wdata[STAT_WIDTH-1:0];
            end
        end
        next_status = (status & ~clr_vec) | set_vec;
        next_irq    = |(next_status & next_mask);
    end

    // read data, valid only in the cycle after the read strobe
    always_comb begin
        next_rdata = '0;
        if (i_read) begin
            if (i_addr == CTRL_OFFSET) begin
                next_rdata[CTRL_WIDTH-1:0] = ctrl;
            end else if (i_addr == STATUS_OFFSET) begin
                next_rdata[STAT_WIDTH-1:0] = status;
            end else if (i_addr == MASK_OFFSET) begin
                next_rdata[STAT_WIDTH-1:0] = mask;
            end
        end
    end

    // register state, frozen while the clock enable is low
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl                  <= CTRL_RESET;
            status                <= STATUS_RESET;
            mask                  <= MASK_RESET;
            o_rdata               <= '0;
            o_irq                 <= 1'b0;
            o_primary_perr_resp   <= CTRL_RESET[CTRL_PRI_RESP_BIT];
            o_secondary_perr_resp <= CTRL_RESET[CTRL_SEC_RESP_BIT];
        end else if (i_ce) begin
            ctrl                  <= next_ctrl;
            status                <= next_status;
            mask                  <= next_mask;
            o_rdata               <= next_rdata;
            o_irq                 <= next_irq;
            o_primary_perr_resp   <= next_ctrl[CTRL_PRI_RESP_BIT];
            o_secondary_perr_resp <= next_ctrl[CTRL_SEC_RESP_BIT];
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // reported events that target each detected flag
    sequence seq_pri_det;
        i_ce && i_err_valid && i_err_bus == BUS_PRIMARY
            && ((i_err_type == TXN_READ && i_err_dir == DIR_UP)
                || (i_err_type != TXN_READ && i_err_dir == DIR_DOWN));
    endsequence

    sequence seq_sec_det;
        i_ce && i_err_valid && i_err_bus == BUS_SECONDARY
            && ((i_err_type == TXN_READ && i_err_dir == DIR_DOWN)
                || (i_err_type != TXN_READ && i_err_dir == DIR_UP));
    endsequence

    // all-ones clear of the status word with no event pending
    sequence seq_clear_all;
        i_ce && i_write && i_addr == STATUS_OFFSET && i_wdata[3:0] == 4'hf
            && !i_err_valid && !pri_pin_err && !sec_pin_err;
    endsequence

    AST_PRI_DET_SET: assert property (
        seq_pri_det |=> status[STAT_PRI_DET_BIT])
        else $error("primary detected flag not set");

    AST_PRI_DET_CAUSE: assert property (
        $rose(status[STAT_PRI_DET_BIT]) |-> $past(pri_det_evt))
        else $error("primary detected flag set without cause");

    AST_SEC_DET_SET: assert property (
        seq_sec_det |=> status[STAT_SEC_DET_BIT])
        else $error("secondary detected flag not set");

    AST_SEC_DET_CAUSE: assert property (
        $rose(status[STAT_SEC_DET_BIT]) |-> $past(sec_det_evt))
        else $error("secondary detected flag set without cause");

    AST_PRI_MDPE_MASTER: assert property (
        $rose(status[STAT_PRI_MDPE_BIT]) |-> $past(i_primary_master))
        else $error("primary master flag set while not master");

    AST_PRI_MDPE_ENABLE: assert property (
        $rose(status[STAT_PRI_MDPE_BIT]) |-> $past(ctrl[CTRL_PRI_RESP_BIT]))
        else $error("primary master flag set while disabled");

    AST_PRI_MDPE_PIN: assert property (
        i_ce && pri_pin_err && i_primary_master && ctrl[CTRL_PRI_RESP_BIT]
            |=> status[STAT_PRI_MDPE_BIT])
        else $error("primary pin error not recorded");

    AST_PRI_MDPE_UP: assert property (
        i_ce && i_err_valid && i_err_bus == BUS_PRIMARY && i_err_dir == DIR_UP
            && i_primary_master && ctrl[CTRL_PRI_RESP_BIT]
            |=> status[STAT_PRI_MDPE_BIT])
        else $error("primary own parity error not recorded");

    AST_SEC_MDPE_MASTER: assert property (
        $rose(status[STAT_SEC_MDPE_BIT]) |-> $past(i_secondary_master))
        else $error("secondary master flag set while not master");

    AST_SEC_MDPE_ENABLE: assert property (
        $rose(status[STAT_SEC_MDPE_BIT]) |-> $past(ctrl[CTRL_SEC_RESP_BIT]))
        else $error("secondary master flag set while disabled");

    AST_SEC_MDPE_PIN: assert property (
        i_ce && sec_pin_err && i_secondary_master && ctrl[CTRL_SEC_RESP_BIT]
            |=> status[STAT_SEC_MDPE_BIT])
        else $error("secondary pin error not recorded");

    AST_DET_NO_ENABLE: assert property (
        seq_pri_det and !ctrl[CTRL_PRI_RESP_BIT]
            |=> status[STAT_PRI_DET_BIT])
        else $error("detected flag gated by response enable");

    AST_SEC_DET_NO_ENABLE: assert property (
        seq_sec_det and !ctrl[CTRL_SEC_RESP_BIT]
            |=> status[STAT_SEC_DET_BIT])
        else $error("secondary detected flag gated by response enable");

    AST_SEC_MDPE_OWN: assert property (
        i_ce && i_err_valid && i_err_bus == BUS_SECONDARY
            && i_err_dir == DIR_DOWN
            && i_secondary_master && ctrl[CTRL_SEC_RESP_BIT]
            |=> status[STAT_SEC_MDPE_BIT])
        else $error("secondary own parity error not recorded");

    AST_CLEAR_ALL: assert property (
        seq_clear_all |=> status == 4'h0)
        else $error("status not cleared by write of ones");

    // a flag only drops on a status write or a reset, never by itself
    AST_STICKY: assert property (
        !$past(i_reset) && ($past(status) & ~status) != 4'h0
            |-> $past(i_write) && $past(i_addr) == STATUS_OFFSET)
        else $error("status flag dropped without a clear");

    // pin path: low pin, two synchroniser stages, then the flag
    sequence seq_pri_pin_seen;
        i_ce && !i_primary_parity_err_n ##1 i_ce
            ##1 i_ce && i_primary_master && ctrl[CTRL_PRI_RESP_BIT];
    endsequence

    sequence seq_sec_pin_seen;
        i_ce && !i_secondary_parity_err_n ##1 i_ce
            ##1 i_ce && i_secondary_master && ctrl[CTRL_SEC_RESP_BIT];
    endsequence

    AST_PRI_PIN_PATH: assert property (
        seq_pri_pin_seen |=> status[STAT_PRI_MDPE_BIT])
        else $error("primary pin error lost on its way to the flag");

    AST_SEC_PIN_PATH: assert property (
        seq_sec_pin_seen |=> status[STAT_SEC_MDPE_BIT])
        else $error("secondary pin error lost on its way to the flag");

    // side outputs mirror the registers that feed them
    AST_IRQ_LEVEL: assert property (
        o_irq == |(status & mask))
        else $error("interrupt line disagrees with status and mask");

    AST_RESP_COPY: assert property (
        o_primary_perr_resp == ctrl[CTRL_PRI_RESP_BIT]
            && o_secondary_perr_resp == ctrl[CTRL_SEC_RESP_BIT])
        else $error("response enable outputs disagree with control");

    // read data stands one cycle only, zero otherwise
    AST_RDATA_IDLE: assert property (
        i_ce && !i_read |=> o_rdata == '0)
        else $error("read data not zero outside a read");

    AST_RDATA_STATUS: assert property (
        i_ce && i_read && i_addr == STATUS_OFFSET
            |=> o_rdata[STAT_WIDTH-1:0] == $past(status))
        else $error("status read returned a stale word");

endmodule : parity_status

//--- dv/pci_target_model.sv
`timescale 1ns/1ps
module pci_target_model (
    // clock and data transfer marks from the bench
    input  wire logic i_clk,
    input  wire logic i_pri_xfer,
    input  wire logic i_sec_xfer,
    input  wire logic i_slow,
    // parity error pins of the targets, pulled up while idle
    output logic      o_primary_parity_err_n,
    output logic      o_secondary_parity_err_n
);
    logic [2:0] pri_pipe = 3'h0;
    logic [2:0] sec_pipe = 3'h0;

    // delay line from data transfer to pin assertion
    always_ff @(posedge i_clk) begin
        pri_pipe <= {pri_pipe[1:0], i_pri_xfer};
        sec_pipe <= {sec_pipe[1:0], i_sec_xfer};
    end

    // pin low for one cycle, two cycles after transfer (three when slow)
    assign o_primary_parity_err_n   = !(i_slow ? pri_pipe[2] : pri_pipe[1]);
    assign o_secondary_parity_err_n = !(i_slow ? sec_pipe[2] : sec_pipe[1]);
endmodule : pci_target_model

//--- dv/test_parity_status.sv
`timescale 1ns/1ps
module test_parity_status
    import parity_status_pkg::*;
;
    // design side signals
    logic                  i_clk, i_reset, i_ce, i_write, i_read;
    logic [ADDR_WIDTH-1:0] i_addr;
    logic [DATA_WIDTH-1:0] i_wdata, o_rdata;
    logic                  i_err_valid, i_primary_master, i_secondary_master;
    txn_kind_type          i_err_type;
    dir_type               i_err_dir;
    bus_type               i_err_bus;
    logic                  pri_pin_n, sec_pin_n, pri_xfer, sec_xfer, slow;
    logic                  o_primary_perr_resp, o_secondary_perr_resp, o_irq;
    int                    failures, n_checks;
    logic [31:0]           rv;
    logic [3:0]            ex;

    // event rows: kind, direction, bus, flags with masters and enables on
    typedef struct packed {
        txn_kind_type t;
        dir_type      d;
        bus_type      b;
        logic [3:0]   e;
    } row_type;
    row_type rows [12] = '{
        '{TXN_READ, DIR_DOWN, BUS_PRIMARY, 4'h0},
        '{TXN_READ, DIR_DOWN, BUS_SECONDARY, 4'ha},
        '{TXN_READ, DIR_UP, BUS_PRIMARY, 4'h5},
        '{TXN_READ, DIR_UP, BUS_SECONDARY, 4'h0},
        '{TXN_POSTED, DIR_DOWN, BUS_PRIMARY, 4'h1},
        '{TXN_POSTED, DIR_DOWN, BUS_SECONDARY, 4'h8},
        '{TXN_POSTED, DIR_UP, BUS_PRIMARY, 4'h4},
        '{TXN_POSTED, DIR_UP, BUS_SECONDARY, 4'h2},
        '{TXN_DELAYED, DIR_DOWN, BUS_PRIMARY, 4'h1},
        '{TXN_DELAYED, DIR_DOWN, BUS_SECONDARY, 4'h8},
        '{TXN_DELAYED, DIR_UP, BUS_PRIMARY, 4'h4},
        '{TXN_DELAYED, DIR_UP, BUS_SECONDARY, 4'h2}};

    parity_status i_dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
        .o_rdata(o_rdata), .i_err_valid(i_err_valid),
        .i_err_type(i_err_type), .i_err_dir(i_err_dir),
        .i_err_bus(i_err_bus), .i_primary_master(i_primary_master),
        .i_secondary_master(i_secondary_master),
        .i_primary_parity_err_n(pri_pin_n),
        .i_secondary_parity_err_n(sec_pin_n),
        .o_primary_perr_resp(o_primary_perr_resp),
        .o_secondary_perr_resp(o_secondary_perr_resp), .o_irq(o_irq));

    pci_target_model i_target (
        .i_clk(i_clk), .i_pri_xfer(pri_xfer), .i_sec_xfer(sec_xfer),
        .i_slow(slow), .o_primary_parity_err_n(pri_pin_n),
        .o_secondary_parity_err_n(sec_pin_n));

    // verdict and end of run
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // compare one result
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_write <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_write <= 1'b0;
    endtask : wr

    // register read, data taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_read <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_read <= 1'b0;
        #1 rv = o_rdata;
    endtask : rd

    // one parity check failure from the datapath
    task automatic ev(input txn_kind_type t, input dir_type d,
                      input bus_type b);
        @(posedge i_clk);
        i_err_valid <= 1'b1;
        i_err_type  <= t;
        i_err_dir   <= d;
        i_err_bus   <= b;
        @(posedge i_clk);
        i_err_valid <= 1'b0;
    endtask : ev

    // bounded wait for the interrupt line
    task automatic wait_irq;
        for (int k = 0; k < 12 && o_irq !== 1'b1; k++) begin
            @(posedge i_clk);
            #1;
        end
        if (o_irq !== 1'b1) begin
            failures++;
            wrap_up();
        end
    endtask : wait_irq

    task automatic irq_is(input logic e);
        repeat (2) @(posedge i_clk);
        #1 chk("irq", {31'h0, e}, {31'h0, o_irq});
    endtask : irq_is

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    initial begin
        {failures, n_checks} = '0;
        {i_reset, i_ce} = 2'h3;
        {i_write, i_read, i_err_valid, pri_xfer, sec_xfer, slow} = '0;
        {i_addr, i_wdata, i_primary_master, i_secondary_master} = '0;
        i_err_type = TXN_READ;
        i_err_dir  = DIR_DOWN;
        i_err_bus  = BUS_PRIMARY;
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        // reset values, unmapped word last
        for (int k = 0; k < 4; k++) begin
            rd(8'(k * 4));
            chk("reset read", 32'h0, rv);
        end
        // unmapped write lands nowhere, bits above a field read zero
        wr(8'h0c, 32'hffffffff);
        wr(CTRL_OFFSET, 32'hffffffff);
        rd(MASK_OFFSET);
        chk("unmapped write", 32'h0, rv);
        rd(CTRL_OFFSET);
        chk("ctrl width", 32'h3, rv);
        // table passes: all on, enables off, masters off
        for (int p = 0; p < 3; p++) begin
            wr(CTRL_OFFSET, (p == 1) ? 32'h0 : 32'h3);
            i_primary_master   <= (p != 2);
            i_secondary_master <= (p != 2);
            foreach (rows[r]) begin
                wr(STATUS_OFFSET, 32'hf);
                ev(rows[r].t, rows[r].d, rows[r].b);
                rd(STATUS_OFFSET);
                ex = rows[r].e & ((p == 0) ? 4'hf : 4'h3);
                chk("det", ex[1:0], rv[1:0]);
                chk("mst", ex[3:2], rv[3:2]);
            end
            chk("resp", (p == 1) ? 2'h0 : 2'h3,
                {o_primary_perr_resp, o_secondary_perr_resp});
        end
        // target pins, prompt and slow, while master and enabled
        wr(MASK_OFFSET, 32'hf);
        wr(CTRL_OFFSET, 32'h3);
        i_primary_master   <= 1'b1;
        i_secondary_master <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(STATUS_OFFSET, 32'hf);
            @(posedge i_clk);
            slow     <= s[1];
            pri_xfer <= !s[0];
            sec_xfer <= s[0];
            @(posedge i_clk);
            {pri_xfer, sec_xfer} <= 2'h0;
            wait_irq();
            rd(STATUS_OFFSET);
            chk("pin flag", s[0] ? 32'h8 : 32'h4, rv);
        end
        // pin while not master leaves the flag clear
        wr(STATUS_OFFSET, 32'hf);
        i_primary_master <= 1'b0;
        pri_xfer <= 1'b1;
        @(posedge i_clk);
        pri_xfer <= 1'b0;
        repeat (8) @(posedge i_clk);
        rd(STATUS_OFFSET);
        chk("pin no master", 32'h0, rv);
        // masked interrupt, then write-one clear against a same-cycle set
        wr(MASK_OFFSET, 32'h1);
        ev(TXN_READ, DIR_UP, BUS_PRIMARY);
        irq_is(1'b1);
        wr(MASK_OFFSET, 32'h0);
        irq_is(1'b0);
        wr(MASK_OFFSET, 32'h1);
        irq_is(1'b1);
        @(posedge i_clk);
        {i_write, i_addr, i_wdata} <= {1'b1, STATUS_OFFSET, 32'h1};
        i_err_valid <= 1'b1;
        @(posedge i_clk);
        {i_write, i_err_valid} <= 2'h0;
        rd(STATUS_OFFSET);
        chk("set over clear", 32'h1, rv);
        @(posedge i_clk);
        #1 chk("rdata after", 32'h0, o_rdata);
        wr(STATUS_OFFSET, 32'h1);
        irq_is(1'b0);
        // clock enable low: event not taken
        @(posedge i_clk);
        i_ce <= 1'b0;
        ev(TXN_READ, DIR_UP, BUS_PRIMARY);
        i_ce <= 1'b1;
        rd(STATUS_OFFSET);
        chk("ce frozen", 32'h0, rv);
        // reset in mid-run clears a set flag
        ev(TXN_POSTED, DIR_UP, BUS_SECONDARY);
        rd(STATUS_OFFSET);
        chk("before reset", 32'h2, rv);
        @(posedge i_clk);
        i_reset <= 1'b1;
        @(posedge i_clk);
        i_reset <= 1'b0;
        rd(STATUS_OFFSET);
        chk("status after reset", 32'h0, rv);
        chk("resp after reset", 2'h0,
            {o_primary_perr_resp, o_secondary_perr_resp});
        wrap_up();
    end
endmodule : test_parity_status
